// ===== bcru_pkg.sv
// Constants shared by the bus command responder.
// Assumes one clock; host command codes are synchronous.
package bcru_pkg;
	localparam int AW = 16;
	localparam int DW = 8;
	localparam int MEM_AW = 10;
	localparam int MEM_DEPTH = 1024;
	localparam logic [AW-1:0] MEM_BASE = 16'h0000;
	localparam logic [AW-1:0] MEM_LAST = 16'h03ff;
	localparam logic [AW-1:0] CNT_RST = 16'h0000;
	localparam logic [DW-1:0] IO_RST = 8'h00;
	// Vector value is arbitrary
	localparam logic [AW-1:0] INT_VECTOR = 16'h0080;
	localparam logic [DW-1:0] IO_A_ADDR = 8'h04;
	localparam logic [DW-1:0] IO_B_ADDR = 8'h05;
	localparam logic [DW-1:0] INTCTL_ADDR = 8'h06;
	localparam logic [DW-1:0] TIMER_ADDR = 8'h07;
	localparam int INTCTL_EN_BIT = 0;
	localparam logic [4:0] C_ADD_DC = 5'h0a;
	localparam logic [4:0] C_RD_PCB_LO = 5'h0b;
	localparam logic [4:0] C_MEM_PC_LO = 5'h0c;
	localparam logic [4:0] C_PC_INC = 5'h0d;
	localparam logic [4:0] C_MEM_DC_LO = 5'h0e;
	localparam logic [4:0] C_VEC_LO = 5'h0f;
	localparam logic [4:0] C_INT_HOLD = 5'h10;
	localparam logic [4:0] C_MEM_DC_HI = 5'h11;
	localparam logic [4:0] C_SAVE_PC = 5'h12;
	localparam logic [4:0] C_VEC_HI = 5'h13;
	localparam logic [4:0] C_LD_PC_HI = 5'h14;
	localparam logic [4:0] C_LD_PCB_HI = 5'h15;
	localparam logic [4:0] C_LD_DC_HI = 5'h16;
	localparam logic [4:0] C_LD_PC_LO = 5'h17;
	localparam logic [4:0] C_LD_PCB_LO = 5'h18;
	localparam logic [4:0] C_LD_DC_LO = 5'h19;
	localparam logic [4:0] C_IO_WR = 5'h1a;
	localparam logic [4:0] C_IO_RD = 5'h1b;
	localparam logic [4:0] C_IDLE = 5'h1c;
	localparam logic [4:0] C_SWAP_DC = 5'h1d;
	localparam logic [4:0] C_RD_PC_LO = 5'h1e;
	localparam logic [4:0] C_RD_PC_HI = 5'h1f;
	typedef enum logic [2:0] {
		BCRU_IRQ_IDLE = 3'b001,
		BCRU_IRQ_PEND = 3'b010,
		BCRU_IRQ_ACK = 3'b100
	} bcru_irq_e;
endpackage

// ===== bcru_cnt_if.sv
// Load strobes and counter values between decoder and counters.
// Assumes strobes are one-cycle pulses on clk.
interface bcru_cnt_if;
	logic        ld_pc_lo;
	logic        ld_pc_hi;
	logic        ld_pcb_lo;
	logic        ld_pcb_hi;
	logic        ld_dc_lo;
	logic        ld_dc_hi;
	logic        add_dc;
	logic        save_pc;
	logic        pc_inc;
	logic        swap_dc;
	logic [7:0]  bus_byte;
	logic [15:0] pc;
	logic [15:0] pcb;
	logic [15:0] dc;
	logic [15:0] adc;
	modport ctl (
		output ld_pc_lo, ld_pc_hi, ld_pcb_lo, ld_pcb_hi, ld_dc_lo,
		output ld_dc_hi, add_dc, save_pc, pc_inc, swap_dc, bus_byte,
		input  pc, pcb, dc, adc
	);
	modport dp (
		input  ld_pc_lo, ld_pc_hi, ld_pcb_lo, ld_pcb_hi, ld_dc_lo,
		input  ld_dc_hi, add_dc, save_pc, pc_inc, swap_dc, bus_byte,
		output pc, pcb, dc, adc
	);
endinterface

// ===== bcru_counters.sv
// Address counters kept identical in every device on the bus.
// Assumes at most one load strobe per counter per cycle.
module bcru_counters (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Decoder side
	bcru_cnt_if.dp   cnt
);
	import bcru_pkg::*;

	logic [AW-1:0] pc_ff;
	logic [AW-1:0] pcb_ff;
	logic [AW-1:0] dc_ff;
	logic [AW-1:0] adc_ff;
	logic [AW-1:0] bus_sx;

	assign bus_sx = {{8{cnt.bus_byte[7]}}, cnt.bus_byte};
	assign cnt.pc = pc_ff;
	assign cnt.pcb = pcb_ff;
	assign cnt.dc = dc_ff;
	assign cnt.adc = adc_ff;

	always_ff @(posedge clk) begin
		if (srst) begin
			pc_ff <= CNT_RST;
			pcb_ff <= CNT_RST;
			dc_ff <= CNT_RST;
			adc_ff <= CNT_RST;
		end else begin
			// Old pc is saved before the low byte load lands
			if (cnt.save_pc)
				pcb_ff <= pc_ff;
			if (cnt.pc_inc)
				pcb_ff <= pc_ff + 16'h0001;
			if (cnt.ld_pc_lo)
				pc_ff[7:0] <= cnt.bus_byte;
			if (cnt.ld_pc_hi)
				pc_ff[15:8] <= cnt.bus_byte;
			if (cnt.ld_pcb_lo)
				pcb_ff[7:0] <= cnt.bus_byte;
			if (cnt.ld_pcb_hi)
				pcb_ff[15:8] <= cnt.bus_byte;
			if (cnt.ld_dc_lo)
				dc_ff[7:0] <= cnt.bus_byte;
			if (cnt.ld_dc_hi)
				dc_ff[15:8] <= cnt.bus_byte;
			if (cnt.add_dc)
				dc_ff <= dc_ff + bus_sx;
			if (cnt.swap_dc) begin
				dc_ff <= adc_ff;
				adc_ff <= dc_ff;
			end
		end
	end
endmodule

// ===== bcru_top.sv
// Bus command responder: decodes the 5-bit command per cycle,
// keeps the address counters, drives the shared data bus.
// Assumes host holds a code for the whole cycle and pulses
// wr_stb once at its end, at least two clocks after the code.

// How it works
// - Code 0A adds signed bus byte to data_counter
// - Code 0B: owner drives backup low byte
// - Code 0C: memory byte into program_counter low
// - Code 0D: backup gets program_counter plus one
// - Code 0E: memory byte into data_counter low
// - Code 0F: vector low, save, load low
// - Code 10 freezes interrupt priority logic
// - Code 11: memory byte into data_counter high
// - Code 12: save counter, load bus low
// - Code 13: vector high into counter high
// - Code 13 clears our pending interrupt
// - Codes 14-16 load bus into high bytes
// - Codes 17-19 load bus into low bytes
// - Code 1A writes previously addressed register
// - Code 1B drives previously addressed port
// - Timer and interrupt control are write-only
// - Code 1D swaps data and alternate counters
// - Code 1E: owner drives counter low byte
// - Code 1F: owner drives counter high byte
// - Answer memory only inside own range
// - All register commands applied by everyone
module bcru_top (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   srst,
	// Host command and data bus
	input  wire logic [4:0]             cmd_code,
	input  wire logic                   wr_stb,
	input  wire logic [bcru_pkg::DW-1:0] db_in,
	output logic [bcru_pkg::DW-1:0]     db_out_ff,
	output logic                        db_oe_ff,
	// Interrupt chain
	input  wire logic                   irq_line,
	input  wire logic                   pri_in,
	output logic                        pri_out_ff,
	output logic                        irq_req_ff,
	// Ports and control registers
	input  wire logic [bcru_pkg::DW-1:0] io_a_in,
	input  wire logic [bcru_pkg::DW-1:0] io_b_in,
	output logic [bcru_pkg::DW-1:0]     io_a_ff,
	output logic [bcru_pkg::DW-1:0]     io_b_ff,
	output logic [bcru_pkg::DW-1:0]     timer_ff,
	output logic [bcru_pkg::DW-1:0]     intctl_ff,
	// Memory fill from user side
	input  wire logic                   fill_en,
	input  wire logic [bcru_pkg::MEM_AW-1:0] fill_addr,
	input  wire logic [bcru_pkg::DW-1:0] fill_data
);
	import bcru_pkg::*;

	bcru_cnt_if cnt ();

	bcru_counters u_cnt (
		.clk  (clk),
		.srst (srst),
		.cnt  (cnt)
	);

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic c_add, c_pcb_lo, c_mpc, c_inc, c_mdl, c_vlo;
	logic c_hold, c_mdh, c_save, c_vhi, c_pch, c_pbh;
	logic c_dch, c_pcl, c_pbl, c_dcl, c_iow, c_ior;
	logic c_swap, c_rpl, c_rph;

	assign c_add = cmd_code == C_ADD_DC;
	assign c_pcb_lo = cmd_code == C_RD_PCB_LO;
	assign c_mpc = cmd_code == C_MEM_PC_LO;
	assign c_inc = cmd_code == C_PC_INC;
	assign c_mdl = cmd_code == C_MEM_DC_LO;
	assign c_vlo = cmd_code == C_VEC_LO;
	assign c_hold = cmd_code == C_INT_HOLD;
	assign c_mdh = cmd_code == C_MEM_DC_HI;
	assign c_save = cmd_code == C_SAVE_PC;
	assign c_vhi = cmd_code == C_VEC_HI;
	assign c_pch = cmd_code == C_LD_PC_HI;
	assign c_pbh = cmd_code == C_LD_PCB_HI;
	assign c_dch = cmd_code == C_LD_DC_HI;
	assign c_pcl = cmd_code == C_LD_PC_LO;
	assign c_pbl = cmd_code == C_LD_PCB_LO;
	assign c_dcl = cmd_code == C_LD_DC_LO;
	assign c_iow = cmd_code == C_IO_WR;
	assign c_ior = cmd_code == C_IO_RD;
	assign c_swap = cmd_code == C_SWAP_DC;
	assign c_rpl = cmd_code == C_RD_PC_LO;
	assign c_rph = cmd_code == C_RD_PC_HI;

	// ----------------------------------------
	// Counter updates, taken on the strobe
	// ----------------------------------------
	// Every device applies these whether it drives or not
	assign cnt.bus_byte = db_in;
	assign cnt.ld_pc_lo = wr_stb & (c_mpc | c_vlo | c_save | c_pcl);
	assign cnt.ld_pc_hi = wr_stb & (c_vhi | c_pch);
	assign cnt.ld_pcb_lo = wr_stb & c_pbl;
	assign cnt.ld_pcb_hi = wr_stb & c_pbh;
	assign cnt.ld_dc_lo = wr_stb & (c_mdl | c_dcl);
	assign cnt.ld_dc_hi = wr_stb & (c_mdh | c_dch);
	assign cnt.add_dc = wr_stb & c_add;
	assign cnt.save_pc = wr_stb & (c_vlo | c_save);
	assign cnt.pc_inc = wr_stb & c_inc;
	assign cnt.swap_dc = wr_stb & c_swap;

	// ----------------------------------------
	// Address space match and memory
	// ----------------------------------------
	logic [DW-1:0] mem [MEM_DEPTH];
	logic          pc_hit;
	logic          pcb_hit;
	logic [AW-1:0] pc_off;
	logic [DW-1:0] mem_rd;

	assign pc_hit = (cnt.pc >= MEM_BASE) && (cnt.pc <= MEM_LAST);
	assign pcb_hit = (cnt.pcb >= MEM_BASE) && (cnt.pcb <= MEM_LAST);
	assign pc_off = cnt.pc - MEM_BASE;
	assign mem_rd = mem[pc_off[MEM_AW-1:0]];

	always_ff @(posedge clk) begin
		if (fill_en)
			mem[fill_addr] <= fill_data;
	end

	// ----------------------------------------
	// Interrupt state
	// ----------------------------------------
	bcru_irq_e irq_st_ff;
	bcru_irq_e nxt_irq_st;
	logic      int_en;
	logic      win_lo;

	assign int_en = intctl_ff[INTCTL_EN_BIT];
	assign win_lo = (irq_st_ff == BCRU_IRQ_PEND) & pri_in;

	always_comb begin
		nxt_irq_st = irq_st_ff;
		case (irq_st_ff)
			BCRU_IRQ_IDLE: begin
				// A new request may not enter during the hold code
				if (irq_line & int_en & ~c_hold)
					nxt_irq_st = BCRU_IRQ_PEND;
			end
			BCRU_IRQ_PEND: begin
				if (wr_stb & c_vlo & pri_in)
					nxt_irq_st = BCRU_IRQ_ACK;
			end
			BCRU_IRQ_ACK: begin
				if (wr_stb & c_vhi)
					nxt_irq_st = BCRU_IRQ_IDLE;
			end
			default: nxt_irq_st = BCRU_IRQ_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst)
			irq_st_ff <= BCRU_IRQ_IDLE;
		else
			irq_st_ff <= nxt_irq_st;
	end

	logic nxt_pri_out;

	// Frozen for the hold code so the chain cannot reshuffle
	assign nxt_pri_out = c_hold ? pri_out_ff
		: pri_in & (irq_st_ff == BCRU_IRQ_IDLE);

	always_ff @(posedge clk) begin
		if (srst) begin
			pri_out_ff <= 1'b1;
			irq_req_ff <= 1'b0;
		end else begin
			pri_out_ff <= nxt_pri_out;
			irq_req_ff <= nxt_irq_st == BCRU_IRQ_PEND;
		end
	end

	// ----------------------------------------
	// Port and control registers
	// ----------------------------------------
	logic [DW-1:0] io_addr_ff;
	logic          hit_a, hit_b, hit_tmr, hit_ic;

	assign hit_a = io_addr_ff == IO_A_ADDR;
	assign hit_b = io_addr_ff == IO_B_ADDR;
	assign hit_tmr = io_addr_ff == TIMER_ADDR;
	assign hit_ic = io_addr_ff == INTCTL_ADDR;

	always_ff @(posedge clk) begin
		if (srst) begin
			io_addr_ff <= IO_RST;
			io_a_ff <= IO_RST;
			io_b_ff <= IO_RST;
			timer_ff <= IO_RST;
			intctl_ff <= IO_RST;
		end else if (wr_stb) begin
			// Bus byte of each cycle is the address for the next
			io_addr_ff <= db_in;
			if (c_iow & hit_a)
				io_a_ff <= db_in;
			if (c_iow & hit_b)
				io_b_ff <= db_in;
			if (c_iow & hit_tmr)
				timer_ff <= db_in;
			if (c_iow & hit_ic)
				intctl_ff <= db_in;
		end
	end

	// ----------------------------------------
	// Data bus drive
	// ----------------------------------------
	logic d_mem, d_pcb, d_vlo, d_vhi, d_io, d_rpl, d_rph;
	logic drive;
	logic [DW-1:0] drv_data;

	assign d_mem = pc_hit & (c_mpc | c_mdl | c_mdh);
	assign d_pcb = pcb_hit & c_pcb_lo;
	assign d_vlo = c_vlo & win_lo;
	assign d_vhi = c_vhi & (irq_st_ff == BCRU_IRQ_ACK);
	// Timer and control addresses never match here
	assign d_io = c_ior & (hit_a | hit_b);
	assign d_rpl = pc_hit & c_rpl;
	assign d_rph = pc_hit & c_rph;
	assign drive = d_mem | d_pcb | d_vlo | d_vhi | d_io | d_rpl | d_rph;

	assign drv_data = d_mem ? mem_rd
		: d_pcb ? cnt.pcb[7:0]
		: d_vlo ? INT_VECTOR[7:0]
		: d_vhi ? INT_VECTOR[15:8]
		: d_io ? (hit_a ? io_a_in : io_b_in)
		: d_rpl ? cnt.pc[7:0]
		: d_rph ? cnt.pc[15:8]
		: 8'h00;

	// Registered drive relies on the code staying put all cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			db_oe_ff <= 1'b0;
			db_out_ff <= 8'h00;
		end else begin
			db_oe_ff <= drive;
			db_out_ff <= drv_data;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence s_idle_held;
		cmd_code == C_IDLE ##1 cmd_code == C_IDLE;
	endsequence

	sequence s_vec_pair;
		(wr_stb && c_vlo && win_lo) ##[1:300] (wr_stb && c_vhi);
	endsequence

	add_dc_a: assert property (wr_stb && c_add |=>
		cnt.dc == $past(cnt.dc) + {{8{$past(db_in[7])}}, $past(db_in)})
		else $error("data counter add wrong");
	pcb_lo_a: assert property (c_pcb_lo && pcb_hit |=>
		db_oe_ff && db_out_ff == $past(cnt.pcb[7:0]))
		else $error("backup low byte not driven");
	mem_pc_lo_a: assert property (wr_stb && c_mpc |=>
		cnt.pc[7:0] == $past(db_in) && cnt.pc[15:8] == $past(cnt.pc[15:8]))
		else $error("counter low load wrong");
	pc_inc_a: assert property (wr_stb && c_inc |=>
		cnt.pcb == $past(cnt.pc) + 16'h0001 && $stable(cnt.pc))
		else $error("backup increment wrong");
	mem_drive_a: assert property (pc_hit && c_mdl |=>
		db_oe_ff && db_out_ff == $past(mem_rd))
		else $error("memory byte not driven");
	vec_lo_a: assert property (wr_stb && c_vlo |=>
		cnt.pcb == $past(cnt.pc) && cnt.pc[7:0] == $past(db_in))
		else $error("vector low cycle wrong");
	int_hold_a: assert property (c_hold |=>
		pri_out_ff == $past(pri_out_ff))
		else $error("priority changed during hold");
	ack_clear_a: assert property (s_vec_pair |=>
		irq_st_ff != BCRU_IRQ_ACK)
		else $error("pending not cleared");
	io_write_a: assert property (wr_stb && c_iow && hit_a |=>
		io_a_ff == $past(db_in))
		else $error("port write lost");
	wo_block_a: assert property (c_ior && (hit_tmr || hit_ic) |=>
		!db_oe_ff)
		else $error("write-only register read");
	swap_dc_a: assert property (wr_stb && c_swap |=>
		cnt.dc == $past(cnt.adc) && cnt.adc == $past(cnt.dc))
		else $error("counter swap wrong");
	pc_hi_a: assert property (c_rph && pc_hit |=>
		db_oe_ff && db_out_ff == $past(cnt.pc[15:8]))
		else $error("counter high not driven");
	idle_rel_a: assert property (s_idle_held |->
		!db_oe_ff && $stable(cnt.pc) && $stable(cnt.dc))
		else $error("idle code had effect");
	bus_rel_a: assert property (!(c_pcb_lo || c_mpc || c_mdl || c_mdh || c_vlo
		|| c_vhi || c_ior || c_rpl || c_rph) |=> !db_oe_ff)
		else $error("bus held without cause");
	pc_lo_rd_a: assert property (c_rpl && pc_hit |=>
		db_oe_ff && db_out_ff == $past(cnt.pc[7:0]))
		else $error("counter low not driven");
	mem_dc_lo_a: assert property (wr_stb && c_mdl |=>
		cnt.dc[7:0] == $past(db_in) && cnt.dc[15:8] == $past(cnt.dc[15:8]))
		else $error("data counter low load wrong");
	mem_dc_hi_a: assert property (wr_stb && c_mdh |=>
		cnt.dc[15:8] == $past(db_in) && cnt.dc[7:0] == $past(cnt.dc[7:0]))
		else $error("data counter high load wrong");
	save_pc_a: assert property (wr_stb && c_save |=>
		cnt.pcb == $past(cnt.pc) && cnt.pc[7:0] == $past(db_in))
		else $error("counter save wrong");
	vec_hi_a: assert property (wr_stb && c_vhi |=>
		cnt.pc[15:8] == $past(db_in) && cnt.pc[7:0] == $past(cnt.pc[7:0]))
		else $error("vector high load wrong");
	vec_drive_a: assert property (c_vlo && win_lo |=>
		db_oe_ff && db_out_ff == INT_VECTOR[7:0])
		else $error("vector low not driven");
	vec_yield_a: assert property (c_vlo && !pri_in |=>
		!db_oe_ff)
		else $error("lower priority drove vector");
	hold_pend_a: assert property (c_hold && irq_st_ff == BCRU_IRQ_IDLE |=>
		irq_st_ff == BCRU_IRQ_IDLE)
		else $error("request entered during hold");
	pcb_hi_a: assert property (wr_stb && c_pbh |=>
		cnt.pcb[15:8] == $past(db_in))
		else $error("backup high load wrong");
	pcb_lo_ld_a: assert property (wr_stb && c_pbl |=>
		cnt.pcb[7:0] == $past(db_in))
		else $error("backup low load wrong");
	port_b_rd_a: assert property (c_ior && hit_b |=>
		db_oe_ff && db_out_ff == $past(io_b_in))
		else $error("port read wrong");
	range_miss_a: assert property (!pc_hit && (c_rpl || c_rph || c_mpc
		|| c_mdl || c_mdh) |=> !db_oe_ff)
		else $error("memory answered outside range");
endmodule

// ===== bcru_host.sv
// Host model: drives the command code, the end strobe and its byte.
// Assumes the device answers one clock after the code settles.
module bcru_host (
	// Clock
	input  wire logic       clk,
	// Device side of the bus
	input  wire logic [7:0] db_out_ff,
	input  wire logic       db_oe_ff,
	output logic [4:0]      cmd_code,
	output logic            wr_stb,
	output logic [7:0]      db_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] host_byte = 8'h00;
	logic       host_oe   = 1'b0;
	initial begin
		cmd_code = 5'h1c;
		wr_stb = 1'b0;
	end
	// Wire level; an undriven bus shows the inverse of the last host byte
	assign db_in = db_oe_ff ? db_out_ff : (host_oe ? host_byte : ~host_byte);
	// One instruction cycle, code held until after its strobe
	task automatic run_cycle(input logic [4:0] code, input logic drv, input logic [7:0] b);
		@(negedge clk);
		cmd_code = code;
		host_oe = drv;
		host_byte = b;
		repeat (2) @(negedge clk);
		wr_stb = 1'b1;
		@(negedge clk);
		wr_stb = 1'b0;
	endtask
endmodule

// ===== bus_command_responder_upper_tb.sv
// Self-checking bench for the bus command responder.
// Assumes the host model above and memory filled before use.
module bus_command_responder_upper_tb;
	import bcru_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	//------------------------------------------------
	// Signals
	//------------------------------------------------
	typedef struct packed { logic oe; logic [7:0] d; } bcru_note_s;
	logic clk = 1'b0, srst = 1'b1, irq_line = 1'b0, fill_en = 1'b0, pri_in = 1'b1;
	logic [4:0] cmd_code;
	logic wr_stb, db_oe_ff, pri_out_ff, irq_req_ff;
	logic [7:0] db_in, db_out_ff, io_a_ff, io_b_ff, timer_ff, intctl_ff;
	logic [7:0] io_a_in = 8'h00, io_b_in = 8'h00, fill_data = 8'h00;
	logic [9:0] fill_addr = 10'h000;
	logic [7:0] mem [0:1023];
	bcru_note_s notes [$];
	int err_total = 0, comparisons = 0, cycles = 0;
	logic [31:0] seed = 32'd60809;
	logic [7:0] lo, m, b2;
	always #2 clk = ~clk;
	bcru_host host_u (.clk(clk), .db_out_ff(db_out_ff), .db_oe_ff(db_oe_ff),
		.cmd_code(cmd_code), .wr_stb(wr_stb), .db_in(db_in));
	bcru_top dut_u (.clk(clk), .srst(srst), .cmd_code(cmd_code), .wr_stb(wr_stb),
		.db_in(db_in), .db_out_ff(db_out_ff), .db_oe_ff(db_oe_ff),
		.irq_line(irq_line), .pri_in(pri_in), .pri_out_ff(pri_out_ff),
		.irq_req_ff(irq_req_ff), .io_a_in(io_a_in), .io_b_in(io_b_in),
		.io_a_ff(io_a_ff), .io_b_ff(io_b_ff), .timer_ff(timer_ff),
		.intctl_ff(intctl_ff), .fill_en(fill_en), .fill_addr(fill_addr),
		.fill_data(fill_data));
	//------------------------------------------------
	// Helpers
	//------------------------------------------------
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input logic [4:0] c, input logic drv, input logic [7:0] b,
		input logic eoe, input logic [7:0] ed);
		notes.push_back('{eoe, ed});
		host_u.run_cycle(c, drv, b);
	endtask
	task automatic io_wr(input logic [7:0] a, input logic [7:0] v);
		cyc(C_IDLE, 1'b1, a, 1'b0, 8'h00);
		cyc(C_IO_WR, 1'b1, v, 1'b0, 8'h00);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	//------------------------------------------------
	// Monitor and timeout
	//------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 20000) begin
			err_total++;
			report_and_stop();
		end
		if (wr_stb === 1'b1 && srst === 1'b0) begin
			if (notes.size() == 0)
				chk("note queue", 8'h01, 8'h00);
			else begin
				bcru_note_s n;
				n = notes.pop_front();
				chk("db_oe_ff", {7'h00, n.oe}, {7'h00, db_oe_ff});
				if (n.oe)
					chk("db_out_ff", n.d, db_out_ff);
			end
		end
	end
	//------------------------------------------------
	// Main sequence
	//------------------------------------------------
	initial begin
		repeat (6) @(negedge clk);
		srst = 1'b0;
		for (int i = 0; i < 1024; i++) begin
			mem[i] = rnd();
			fill_en = 1'b1;
			fill_addr = i[9:0];
			fill_data = mem[i];
			@(negedge clk);
		end
		fill_en = 1'b0;
		lo = rnd();
		cyc(C_LD_PC_HI, 1'b1, 8'h01, 1'b0, 8'h00);
		cyc(C_LD_PC_LO, 1'b1, lo, 1'b0, 8'h00);
		cyc(C_RD_PC_LO, 1'b0, rnd(), 1'b1, lo);
		cyc(C_RD_PC_HI, 1'b0, rnd(), 1'b1, 8'h01);
		cyc(C_PC_INC, 1'b1, rnd(), 1'b0, 8'h00);
		cyc(C_RD_PCB_LO, 1'b0, rnd(), 1'b1, lo + 8'h01);
		cyc(C_RD_PC_LO, 1'b0, rnd(), 1'b1, lo);
		m = mem[{2'h1, lo}];
		cyc(C_MEM_PC_LO, 1'b0, rnd(), 1'b1, m);
		cyc(C_RD_PC_LO, 1'b0, rnd(), 1'b1, m);
		b2 = rnd();
		cyc(C_SAVE_PC, 1'b1, b2, 1'b0, 8'h00);
		cyc(C_RD_PCB_LO, 1'b0, rnd(), 1'b1, m);
		cyc(C_RD_PC_LO, 1'b0, rnd(), 1'b1, b2);
		cyc(C_MEM_DC_LO, 1'b0, rnd(), 1'b1, mem[{2'h1, b2}]);
		cyc(C_MEM_DC_HI, 1'b0, rnd(), 1'b1, mem[{2'h1, b2}]);
		cyc(C_ADD_DC, 1'b1, rnd(), 1'b0, 8'h00);
		cyc(C_SWAP_DC, 1'b1, rnd(), 1'b0, 8'h00);
		cyc(C_LD_DC_HI, 1'b1, rnd(), 1'b0, 8'h00);
		cyc(C_LD_DC_LO, 1'b1, rnd(), 1'b0, 8'h00);
		m = rnd();
		cyc(C_LD_PCB_HI, 1'b1, 8'h02, 1'b0, 8'h00);
		cyc(C_LD_PCB_LO, 1'b1, m, 1'b0, 8'h00);
		cyc(C_RD_PCB_LO, 1'b0, rnd(), 1'b1, m);
		cyc(C_IDLE, 1'b1, rnd(), 1'b0, 8'h00);
		cyc(C_RD_PC_LO, 1'b0, rnd(), 1'b1, b2);
		cyc(C_LD_PC_HI, 1'b1, 8'h04, 1'b0, 8'h00);
		cyc(C_RD_PC_LO, 1'b0, rnd(), 1'b0, 8'h00);
		cyc(C_MEM_PC_LO, 1'b0, rnd(), 1'b0, 8'h00);
		cyc(C_LD_PC_HI, 1'b1, 8'h03, 1'b0, 8'h00);
		cyc(C_LD_PC_LO, 1'b1, 8'hff, 1'b0, 8'h00);
		cyc(C_RD_PC_HI, 1'b0, rnd(), 1'b1, 8'h03);
		cyc(C_PC_INC, 1'b1, rnd(), 1'b0, 8'h00);
		cyc(C_RD_PCB_LO, 1'b0, rnd(), 1'b0, 8'h00);
		m = rnd();
		io_a_in = rnd();
		io_wr(IO_A_ADDR, m);
		chk("io_a_ff", m, io_a_ff);
		cyc(C_IDLE, 1'b1, IO_A_ADDR, 1'b0, 8'h00);
		cyc(C_IO_RD, 1'b0, rnd(), 1'b1, io_a_in);
		io_b_in = rnd();
		io_wr(IO_B_ADDR, m);
		chk("io_b_ff", m, io_b_ff);
		cyc(C_IDLE, 1'b1, IO_B_ADDR, 1'b0, 8'h00);
		cyc(C_IO_RD, 1'b0, rnd(), 1'b1, io_b_in);
		io_wr(TIMER_ADDR, m);
		chk("timer_ff", m, timer_ff);
		cyc(C_IDLE, 1'b1, TIMER_ADDR, 1'b0, 8'h00);
		cyc(C_IO_RD, 1'b0, rnd(), 1'b0, 8'h00);
		io_wr(INTCTL_ADDR, 8'h01);
		chk("intctl_ff", 8'h01, intctl_ff);
		cyc(C_IDLE, 1'b1, INTCTL_ADDR, 1'b0, 8'h00);
		cyc(C_IO_RD, 1'b0, rnd(), 1'b0, 8'h00);
		// Request rises while the hold code already stands
		cyc(C_INT_HOLD, 1'b1, rnd(), 1'b0, 8'h00);
		irq_line = 1'b1;
		cyc(C_INT_HOLD, 1'b1, rnd(), 1'b0, 8'h00);
		chk("irq_req_ff", 8'h00, {7'h00, irq_req_ff});
		chk("pri_out_ff", 8'h01, {7'h00, pri_out_ff});
		cyc(C_IDLE, 1'b1, rnd(), 1'b0, 8'h00);
		chk("irq_req_ff", 8'h01, {7'h00, irq_req_ff});
		chk("pri_out_ff", 8'h00, {7'h00, pri_out_ff});
		// A higher device wins: this one must stay off the bus
		pri_in = 1'b0;
		cyc(C_VEC_LO, 1'b1, 8'hff, 1'b0, 8'h00);
		chk("irq_req_ff", 8'h01, {7'h00, irq_req_ff});
		pri_in = 1'b1;
		cyc(C_VEC_LO, 1'b0, rnd(), 1'b1, INT_VECTOR[7:0]);
		irq_line = 1'b0;
		cyc(C_VEC_HI, 1'b0, rnd(), 1'b1, INT_VECTOR[15:8]);
		@(negedge clk);
		chk("irq_req_ff", 8'h00, {7'h00, irq_req_ff});
		chk("pri_out_ff", 8'h01, {7'h00, pri_out_ff});
		cyc(C_RD_PCB_LO, 1'b0, rnd(), 1'b1, 8'hff);
		cyc(C_RD_PC_LO, 1'b0, rnd(), 1'b1, INT_VECTOR[7:0]);
		cyc(C_RD_PC_HI, 1'b0, rnd(), 1'b1, INT_VECTOR[15:8]);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		chk("io_a_ff", 8'h00, io_a_ff);
		chk("db_oe_ff", 8'h00, {7'h00, db_oe_ff});
		cyc(C_RD_PC_HI, 1'b0, rnd(), 1'b1, 8'h00);
		repeat (2) @(negedge clk);
		report_and_stop();
	end
endmodule
